// ### irag_top.sv
// Pointer register file and effective address generator.
`timescale 1ns/1ps
module irag_top #(
    parameter int NUM_TASK = irag_pkg::NUM_TASK,
    parameter logic [irag_pkg::PTR_W-1:0] MEM_LIMIT = irag_pkg::MEM_LIMIT_DEF
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Indirect address request and result.
    input wire irag_pkg::irag_req_t req_i,
    output irag_pkg::irag_ea_t ea_o,
    // Direct pointer operand access.
    input wire irag_pkg::irag_dreq_t dreq_i,
    output irag_pkg::irag_dres_t dres_o,
    // Search result write to pointer zero.
    input wire logic found_valid_i,
    input wire logic [irag_pkg::TASK_W-1:0] found_task_i,
    input wire logic [irag_pkg::PTR_W-1:0] found_addr_i,
    // Mode, retain and power control.
    input wire logic mode_change_i,
    input wire logic user_fatal_error_i,
    input wire logic power_up_i,
    input wire logic memory_retain_control_i,
    input wire logic retain_protected_i,
    input wire logic share_banks_i,
    // Programming tool port.
    input wire logic tool_rd_i,
    input wire logic tool_wr_i,
    input wire logic [irag_pkg::PTR_IDX_W-1:0] tool_sel_i,
    output logic [irag_pkg::PTR_W-1:0] tool_rdata_o,
    output logic tool_err_o,
    // Network host command port.
    input wire logic host_req_i,
    output logic host_err_o
);
    localparam int PW = irag_pkg::PTR_W;
    localparam int NP = irag_pkg::NUM_PTR;

    // ******************************************
    // State
    // ******************************************
    typedef struct packed {
        logic [NUM_TASK-1:0][NP-1:0][PW-1:0] ptr;
        logic [irag_pkg::TASK_W-1:0] last_task;
        irag_pkg::irag_ea_t ea;
        irag_pkg::irag_dres_t dres;
        logic [PW-1:0] tool_rdata;
        logic tool_err;
        logic host_err;
    } irag_state_t;

    irag_state_t st_reg;
    irag_state_t st_next;

    logic [irag_pkg::TASK_W-1:0] bank;
    logic [irag_pkg::TASK_W-1:0] dbank;
    logic [irag_pkg::TASK_W-1:0] fbank;
    logic [PW-1:0] cur;
    logic [PW-1:0] step;
    logic [PW-1:0] sum;
    logic [PW-1:0] dcur;
    logic clear_all;
    logic direct_ok;

    // ******************************************
    // Next state
    // ******************************************
    always_comb begin
        st_next = st_reg;
        st_next.ea.valid = 1'b0;
        st_next.dres.valid = 1'b0;
        st_next.dres.refused = 1'b0;
        st_next.tool_err = 1'b0;
        st_next.host_err = 1'b0;
        bank = share_banks_i ? '0 : req_i.task_id;
        dbank = share_banks_i ? '0 : dreq_i.task_id;
        fbank = share_banks_i ? '0 : found_task_i;
        cur = st_reg.ptr[bank][req_i.ptr_sel];
        dcur = st_reg.ptr[dbank][dreq_i.ptr_sel];
        step = req_i.step_two ? irag_pkg::STEP_TWO : irag_pkg::STEP_ONE;
        sum = cur;
        direct_ok = (dreq_i.op != irag_pkg::IRAG_OP_OTHER);
        // Clearing events, retain bit and protection decide.
        clear_all = (mode_change_i && !memory_retain_control_i)
            || (power_up_i && !(memory_retain_control_i && retain_protected_i));
        if (req_i.valid) begin
            case (req_i.mode)
                irag_pkg::IRAG_AM_PLAIN: begin
                    sum = cur;
                end
                irag_pkg::IRAG_AM_CONST: begin
                    sum = cur + PW'(signed'(req_i.const_ofs));
                end
                irag_pkg::IRAG_AM_OFSREG: begin
                    sum = cur + PW'(signed'(req_i.reg_ofs));
                end
                irag_pkg::IRAG_AM_POSTINC: begin
                    sum = cur;
                    st_next.ptr[bank][req_i.ptr_sel] = cur + step;
                end
                irag_pkg::IRAG_AM_PREDEC: begin
                    sum = cur - step;
                    st_next.ptr[bank][req_i.ptr_sel] = cur - step;
                end
                default: begin
                    sum = cur;
                end
            endcase
            st_next.last_task = bank;
            st_next.ea.valid = 1'b1;
            st_next.ea.addr = sum;
            st_next.ea.word_addr = req_i.is_bit ? sum[PW-1:irag_pkg::BIT_NUM_W]
                                                : sum[PW-irag_pkg::BIT_NUM_W-1:0];
            st_next.ea.bit_num = req_i.is_bit ? sum[irag_pkg::BIT_NUM_W-1:0] : '0;
            st_next.ea.illegal = (sum >= MEM_LIMIT);
        end
        if (dreq_i.valid) begin
            st_next.dres.valid = 1'b1;
            st_next.dres.refused = !direct_ok;
            st_next.dres.rdata = dcur;
            st_next.last_task = dbank;
            if (direct_ok) begin
                case (dreq_i.op)
                    irag_pkg::IRAG_OP_LOAD_ADDR, irag_pkg::IRAG_OP_LOAD_CNT,
                    irag_pkg::IRAG_OP_DMOVE, irag_pkg::IRAG_OP_DXCHG,
                    irag_pkg::IRAG_OP_SETREC: begin
                        st_next.ptr[dbank][dreq_i.ptr_sel] = dreq_i.wdata;
                    end
                    irag_pkg::IRAG_OP_DINC: begin
                        st_next.ptr[dbank][dreq_i.ptr_sel] = dcur + irag_pkg::STEP_ONE;
                    end
                    irag_pkg::IRAG_OP_DDEC: begin
                        st_next.ptr[dbank][dreq_i.ptr_sel] = dcur - irag_pkg::STEP_ONE;
                    end
                    irag_pkg::IRAG_OP_DADD: begin
                        st_next.ptr[dbank][dreq_i.ptr_sel] = dcur + dreq_i.wdata;
                    end
                    irag_pkg::IRAG_OP_DSUB: begin
                        st_next.ptr[dbank][dreq_i.ptr_sel] = dcur - dreq_i.wdata;
                    end
                    default: begin
                        st_next.dres.rdata = dcur;
                    end
                endcase
            end
        end
        if (found_valid_i) begin
            st_next.ptr[fbank][irag_pkg::RESULT_PTR] = found_addr_i;
        end
        if (tool_rd_i) begin
            st_next.tool_rdata = st_reg.ptr[st_reg.last_task][tool_sel_i];
        end
        if (tool_wr_i) begin
            st_next.tool_err = 1'b1;
        end
        if (host_req_i) begin
            st_next.host_err = 1'b1;
        end
        if (clear_all) begin
            st_next.ptr = '0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ea_o = st_reg.ea;
    assign dres_o = st_reg.dres;
    assign tool_rdata_o = st_reg.tool_rdata;
    assign tool_err_o = st_reg.tool_err;
    assign host_err_o = st_reg.host_err;

    // ******************************************
    // Assertions
    // ******************************************
    property p_plain;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_i.valid && req_i.mode == irag_pkg::IRAG_AM_PLAIN && !req_i.is_bit)
            |=> (ea_o.valid && ea_o.addr == $past(cur));
    endproperty
    a_plain: assert property (p_plain) else $error("Plain address mismatch.");

    property p_const;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_i.valid && req_i.mode == irag_pkg::IRAG_AM_CONST)
            |=> ea_o.addr == $past(cur) + PW'(signed'($past(req_i.const_ofs)));
    endproperty
    a_const: assert property (p_const) else $error("Constant offset wrong.");

    property p_ofsreg;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_i.valid && req_i.mode == irag_pkg::IRAG_AM_OFSREG)
            |=> ea_o.addr == $past(cur) + PW'(signed'($past(req_i.reg_ofs)));
    endproperty
    a_ofsreg: assert property (p_ofsreg) else $error("Register offset wrong.");

    property p_postinc;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_i.valid && req_i.mode == irag_pkg::IRAG_AM_POSTINC && !clear_all
            && !found_valid_i && !dreq_i.valid)
            |=> (ea_o.addr == $past(cur)) && (ea_o.addr + $past(step) ==
                st_reg.ptr[$past(bank)][$past(req_i.ptr_sel)]);
    endproperty
    a_postinc: assert property (p_postinc) else $error("Post-increment wrong.");

    property p_predec;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_i.valid && req_i.mode == irag_pkg::IRAG_AM_PREDEC && !clear_all
            && !found_valid_i && !dreq_i.valid)
            |=> ea_o.addr == st_reg.ptr[$past(bank)][$past(req_i.ptr_sel)];
    endproperty
    a_predec: assert property (p_predec) else $error("Pre-decrement wrong.");

    property p_bitsplit;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_i.valid && req_i.is_bit)
            |=> {ea_o.word_addr, ea_o.bit_num} == ea_o.addr;
    endproperty
    a_bitsplit: assert property (p_bitsplit) else $error("Bit split wrong.");

    property p_refuse;
        @(posedge ref_clk_i) disable iff (rst_i)
        (dreq_i.valid && dreq_i.op == irag_pkg::IRAG_OP_OTHER)
            |=> dres_o.valid && dres_o.refused;
    endproperty
    a_refuse: assert property (p_refuse) else $error("Direct op not refused.");

    property p_found;
        @(posedge ref_clk_i) disable iff (rst_i)
        (found_valid_i && !clear_all)
            |=> st_reg.ptr[$past(fbank)][irag_pkg::RESULT_PTR] == $past(found_addr_i);
    endproperty
    a_found: assert property (p_found) else $error("Found address not stored.");

    property p_clear;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode_change_i && !memory_retain_control_i) |=> st_reg.ptr == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("Pointers not cleared.");

    property p_keep;
        @(posedge ref_clk_i) disable iff (rst_i)
        ((mode_change_i || user_fatal_error_i) && memory_retain_control_i && !power_up_i
            && !req_i.valid && !dreq_i.valid && !found_valid_i)
            |=> $stable(st_reg.ptr);
    endproperty
    a_keep: assert property (p_keep) else $error("Retained pointers changed.");

    property p_tool;
        @(posedge ref_clk_i) disable iff (rst_i)
        tool_wr_i |=> tool_err_o;
    endproperty
    a_tool: assert property (p_tool) else $error("Tool write not rejected.");

    property p_host;
        @(posedge ref_clk_i) disable iff (rst_i)
        host_req_i |=> host_err_o;
    endproperty
    a_host: assert property (p_host) else $error("Host access not refused.");

    property p_word;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_i.valid && !req_i.is_bit)
            |=> ea_o.word_addr == ea_o.addr[PW-irag_pkg::BIT_NUM_W-1:0] && ea_o.bit_num == '0;
    endproperty
    a_word: assert property (p_word) else $error("Word address wrong.");

    property p_rdata;
        @(posedge ref_clk_i) disable iff (rst_i)
        dreq_i.valid
            |=> dres_o.valid && dres_o.rdata == $past(dcur);
    endproperty
    a_rdata: assert property (p_rdata) else $error("Direct read data wrong.");

    property p_load;
        @(posedge ref_clk_i) disable iff (rst_i)
        (dreq_i.valid && dreq_i.op == irag_pkg::IRAG_OP_LOAD_ADDR && !clear_all
            && !found_valid_i)
            |=> st_reg.ptr[$past(dbank)][$past(dreq_i.ptr_sel)] == $past(dreq_i.wdata);
    endproperty
    a_load: assert property (p_load) else $error("Pointer load wrong.");

    property p_dinc;
        @(posedge ref_clk_i) disable iff (rst_i)
        (dreq_i.valid && dreq_i.op == irag_pkg::IRAG_OP_DINC && !clear_all
            && !found_valid_i)
            |=> st_reg.ptr[$past(dbank)][$past(dreq_i.ptr_sel)]
                == $past(dcur) + irag_pkg::STEP_ONE;
    endproperty
    a_dinc: assert property (p_dinc) else $error("Increment wrong.");

    property p_ddec;
        @(posedge ref_clk_i) disable iff (rst_i)
        (dreq_i.valid && dreq_i.op == irag_pkg::IRAG_OP_DDEC && !clear_all
            && !found_valid_i)
            |=> st_reg.ptr[$past(dbank)][$past(dreq_i.ptr_sel)]
                == $past(dcur) - irag_pkg::STEP_ONE;
    endproperty
    a_ddec: assert property (p_ddec) else $error("Decrement wrong.");

    property p_dadd;
        @(posedge ref_clk_i) disable iff (rst_i)
        (dreq_i.valid && dreq_i.op == irag_pkg::IRAG_OP_DADD && !clear_all
            && !found_valid_i)
            |=> st_reg.ptr[$past(dbank)][$past(dreq_i.ptr_sel)]
                == $past(dcur) + $past(dreq_i.wdata);
    endproperty
    a_dadd: assert property (p_dadd) else $error("Add wrong.");

    property p_dsub;
        @(posedge ref_clk_i) disable iff (rst_i)
        (dreq_i.valid && dreq_i.op == irag_pkg::IRAG_OP_DSUB && !clear_all
            && !found_valid_i)
            |=> st_reg.ptr[$past(dbank)][$past(dreq_i.ptr_sel)]
                == $past(dcur) - $past(dreq_i.wdata);
    endproperty
    a_dsub: assert property (p_dsub) else $error("Subtract wrong.");

    property p_refkeep;
        @(posedge ref_clk_i) disable iff (rst_i)
        (dreq_i.valid && dreq_i.op == irag_pkg::IRAG_OP_OTHER && !req_i.valid
            && !found_valid_i && !clear_all)
            |=> $stable(st_reg.ptr);
    endproperty
    a_refkeep: assert property (p_refkeep) else $error("Refused op changed a pointer.");

    property p_power;
        @(posedge ref_clk_i) disable iff (rst_i)
        (power_up_i && !(memory_retain_control_i && retain_protected_i))
            |=> st_reg.ptr == '0;
    endproperty
    a_power: assert property (p_power) else $error("Pointers not cleared at power-up.");

    property p_powkeep;
        @(posedge ref_clk_i) disable iff (rst_i)
        (power_up_i && memory_retain_control_i && retain_protected_i
            && !req_i.valid && !dreq_i.valid && !found_valid_i)
            |=> $stable(st_reg.ptr);
    endproperty
    a_powkeep: assert property (p_powkeep) else $error("Protected pointers changed.");

    property p_illegal;
        @(posedge ref_clk_i) disable iff (rst_i)
        req_i.valid
            |=> ea_o.illegal == (ea_o.addr >= MEM_LIMIT);
    endproperty
    a_illegal: assert property (p_illegal) else $error("Illegal access flag wrong.");

    property p_eaonly;
        @(posedge ref_clk_i) disable iff (rst_i)
        !req_i.valid |=> !ea_o.valid;
    endproperty
    a_eaonly: assert property (p_eaonly) else $error("Address valid without request.");

    property p_hostonly;
        @(posedge ref_clk_i) disable iff (rst_i)
        !host_req_i |=> !host_err_o;
    endproperty
    a_hostonly: assert property (p_hostonly) else $error("Host error without request.");

    property p_dresonly;
        @(posedge ref_clk_i) disable iff (rst_i)
        !dreq_i.valid |=> !dres_o.valid;
    endproperty
    a_dresonly: assert property (p_dresonly) else $error("Direct result without request.");

    property p_toolkeep;
        @(posedge ref_clk_i) disable iff (rst_i)
        (tool_wr_i && !req_i.valid && !dreq_i.valid && !found_valid_i && !clear_all)
            |=> $stable(st_reg.ptr);
    endproperty
    a_toolkeep: assert property (p_toolkeep) else $error("Tool write changed a pointer.");
endmodule

// ### irag_pkg.sv
// Package with constants and carrier types for the index register address generator.
// Overview of operation
// - Plain indirect mode uses the pointer content unchanged as effective address.
// - Constant-offset mode adds a signed constant from -2048 to 2047 to the pointer.
// - Register-offset mode adds the signed offset register content to the pointer.
// - Auto-increment uses the current pointer, then writes back pointer plus 1 or 2.
// - Auto-decrement subtracts 1 or 2, stores it, then uses it as address.
// - Word operands use the effective value directly as a word address.
// - Bit operands split the value into word address and low-digit bit number.
// - Direct operands act on the pointer register's own two-word content.
// - Direct pointer operands are allowed only for listed double-word instructions.
// - Search, maximum and minimum results load the found address into pointer zero.
// - Mode changes clear all pointers when the memory-retain control is off.
// - Power-up clears all pointers unless retain is on and protected.
// - With retain on, pointers survive user fatal errors and mode changes.
// - With retain on and protected, pointers survive a power cycle.
// - Each task has its own bank of sixteen pointer registers by default.
// - The tool may read only the last task's pointers and may never write them.
// - Networked host commands get no access to the pointer registers.
// - A setting lets all tasks share one common pointer bank.
// - An effective address outside valid memory raises an illegal-access error.
// - All memory forms one flat pointer address space, excluding registers and flags.
// - Offset register contents are sixteen-bit signed two's complement values.
package irag_pkg;
    localparam int PTR_W = 32;
    localparam int NUM_PTR = 16;
    localparam int PTR_IDX_W = 4;
    localparam int NUM_TASK = 4;
    localparam int TASK_W = 2;
    localparam int CONST_W = 12;
    localparam int OFS_W = 16;
    localparam int BIT_NUM_W = 4;
    localparam logic [PTR_W-1:0] PTR_RESET = 32'h0000_0000;
    localparam logic [PTR_W-1:0] MEM_LIMIT_DEF = 32'h0010_0000;
    localparam logic [PTR_W-1:0] STEP_ONE = 32'h0000_0001;
    localparam logic [PTR_W-1:0] STEP_TWO = 32'h0000_0002;
    localparam logic [PTR_IDX_W-1:0] RESULT_PTR = 4'h0;

    typedef enum logic [2:0] {
        IRAG_AM_PLAIN = 3'h0,
        IRAG_AM_CONST = 3'h1,
        IRAG_AM_OFSREG = 3'h2,
        IRAG_AM_POSTINC = 3'h3,
        IRAG_AM_PREDEC = 3'h4
    } irag_mode_t;

    typedef enum logic [3:0] {
        IRAG_OP_LOAD_ADDR = 4'h0,
        IRAG_OP_LOAD_CNT = 4'h1,
        IRAG_OP_DMOVE = 4'h2,
        IRAG_OP_DXCHG = 4'h3,
        IRAG_OP_SETREC = 4'h4,
        IRAG_OP_GETREC = 4'h5,
        IRAG_OP_DINC = 4'h6,
        IRAG_OP_DDEC = 4'h7,
        IRAG_OP_DCMP = 4'h8,
        IRAG_OP_DADD = 4'h9,
        IRAG_OP_DSUB = 4'ha,
        IRAG_OP_OTHER = 4'hf
    } irag_dop_t;

    typedef struct packed {
        logic valid;
        logic [TASK_W-1:0] task_id;
        logic [PTR_IDX_W-1:0] ptr_sel;
        irag_mode_t mode;
        logic step_two;
        logic is_bit;
        logic [CONST_W-1:0] const_ofs;
        logic [OFS_W-1:0] reg_ofs;
    } irag_req_t;

    typedef struct packed {
        logic valid;
        logic [TASK_W-1:0] task_id;
        logic [PTR_IDX_W-1:0] ptr_sel;
        irag_dop_t op;
        logic [PTR_W-1:0] wdata;
    } irag_dreq_t;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic [PTR_W-1:0] addr;
        logic [PTR_W-BIT_NUM_W-1:0] word_addr;
        logic [BIT_NUM_W-1:0] bit_num;
    } irag_ea_t;

    typedef struct packed {
        logic valid;
        logic refused;
        logic [PTR_W-1:0] rdata;
    } irag_dres_t;
endpackage

// ### irag_engine.sv
// Partner model of the instruction execution engine that issues operand requests.
`timescale 1ns/1ps
module irag_engine (
    // Clock.
    input wire logic ref_clk_i,
    // Requests towards the pointer file.
    output irag_pkg::irag_req_t req_o,
    output irag_pkg::irag_dreq_t dreq_o
);
    // ****************************************
    // Request drivers.
    // ****************************************
    initial begin
        req_o = '0;
        dreq_o = '0;
    end
    // Holds one indirect operand request for exactly one cycle.
    task automatic ind(input irag_pkg::irag_req_t q);
        @(posedge ref_clk_i);
        req_o <= q;
        @(posedge ref_clk_i);
        req_o.valid <= 1'b0;
    endtask
    // Holds one direct operand request for exactly one cycle.
    task automatic dir(input irag_pkg::irag_dreq_t q);
        @(posedge ref_clk_i);
        dreq_o <= q;
        @(posedge ref_clk_i);
        dreq_o.valid <= 1'b0;
    endtask
endmodule

// ### irag_top_tb.sv
// Self-checking testbench of the pointer file and address generator.
`timescale 1ns/1ps
module irag_top_tb;
    // ****************************************
    // Signals and instances.
    // ****************************************
    logic ref_clk_i = 1'b0, rst_i = 1'b1;
    irag_pkg::irag_req_t req_i, r;
    irag_pkg::irag_dreq_t dreq_i;
    irag_pkg::irag_ea_t ea_o;
    irag_pkg::irag_dres_t dres_o;
    irag_pkg::irag_dop_t op;
    logic found_valid_i = 1'b0, mode_change_i = 1'b0, user_fatal_error_i = 1'b0;
    logic power_up_i = 1'b0, memory_retain_control_i = 1'b0, retain_protected_i = 1'b0;
    logic share_banks_i = 1'b0, tool_rd_i = 1'b0, tool_wr_i = 1'b0, host_req_i = 1'b0;
    logic [1:0] found_task_i = 2'h0;
    logic [3:0] tool_sel_i = 4'h0;
    logic [31:0] found_addr_i = 32'h0, tool_rdata_o, w;
    logic tool_err_o, host_err_o;
    logic [31:0] m [4][16] = '{default: '0};
    int checks = 0, mismatches = 0, seed = 32'hecac26da;
    always #50 ref_clk_i = ~ref_clk_i;
    irag_engine eng (.ref_clk_i, .req_o(req_i), .dreq_o(dreq_i));
    irag_top DUT (.ref_clk_i, .rst_i, .req_i, .ea_o, .dreq_i, .dres_o, .found_valid_i,
        .found_task_i, .found_addr_i, .mode_change_i, .user_fatal_error_i, .power_up_i,
        .memory_retain_control_i, .retain_protected_i, .share_banks_i, .tool_rd_i,
        .tool_wr_i, .tool_sel_i, .tool_rdata_o, .tool_err_o, .host_req_i, .host_err_o);
    // ****************************************
    // Tasks.
    // ****************************************
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Works out a pointer after a direct operation.
    function automatic logic [31:0] dop(input irag_pkg::irag_dop_t o, input logic [31:0] v, w);
        case (o)
            irag_pkg::IRAG_OP_GETREC, irag_pkg::IRAG_OP_DCMP, irag_pkg::IRAG_OP_OTHER: return v;
            irag_pkg::IRAG_OP_DINC: return v + 32'h1;
            irag_pkg::IRAG_OP_DDEC: return v - 32'h1;
            irag_pkg::IRAG_OP_DADD: return v + w;
            irag_pkg::IRAG_OP_DSUB: return v - w;
            default: return w;
        endcase
    endfunction
    // Loads a pointer directly and checks the old content returned.
    task automatic load(input logic [1:0] t, input logic [3:0] p, input logic [31:0] v);
        logic [1:0] b;
        eng.dir('{1'b1, t, p, irag_pkg::IRAG_OP_LOAD_ADDR, v});
        b = share_banks_i ? 2'h0 : t;
        @(negedge ref_clk_i);
        cmp(dres_o.valid, 1'b1, "dvalid");
        cmp(dres_o.rdata, m[b][p], "old");
        m[b][p] = v;
    endtask
    // Issues one indirect request and checks the effective address.
    task automatic ind(input irag_pkg::irag_req_t q);
        logic [1:0] b;
        logic [31:0] p, a, s;
        b = share_banks_i ? 2'h0 : q.task_id;
        p = m[b][q.ptr_sel];
        s = q.step_two ? 32'h2 : 32'h1;
        a = p;
        case (q.mode)
            irag_pkg::IRAG_AM_CONST: a = p + 32'(signed'(q.const_ofs));
            irag_pkg::IRAG_AM_OFSREG: a = p + 32'(signed'(q.reg_ofs));
            irag_pkg::IRAG_AM_POSTINC: m[b][q.ptr_sel] = p + s;
            irag_pkg::IRAG_AM_PREDEC: begin
                a = p - s;
                m[b][q.ptr_sel] = a;
            end
            default: a = p;
        endcase
        eng.ind(q);
        @(negedge ref_clk_i);
        cmp(ea_o.valid, 1'b1, "valid");
        cmp(ea_o.addr, a, "addr");
        cmp(ea_o.illegal, a >= irag_pkg::MEM_LIMIT_DEF, "illegal");
        cmp(ea_o.word_addr, q.is_bit ? a[31:4] : a[27:0], "word");
        cmp(ea_o.bit_num, q.is_bit ? a[3:0] : 4'h0, "bit");
    endtask
    task automatic plain(input logic [1:0] t, input logic [3:0] p);
        ind('{1'b1, t, p, irag_pkg::IRAG_AM_PLAIN, 1'b0, 1'b0, 12'h0, 16'h0});
    endtask
    // Sets retain levels, pulses {mode change, power-up, fatal error}, then probes.
    task automatic ctl(input logic [4:0] c);
        @(posedge ref_clk_i);
        memory_retain_control_i <= c[1];
        retain_protected_i <= c[0];
        @(posedge ref_clk_i);
        {mode_change_i, power_up_i, user_fatal_error_i} <= c[4:2];
        @(posedge ref_clk_i);
        {mode_change_i, power_up_i, user_fatal_error_i} <= 3'h0;
        if ((c[4] && !c[1]) || (c[3] && !(c[1] && c[0]))) m = '{default: '0};
        plain(2'h1, 4'h3);
    endtask
    // ****************************************
    // Test sequence.
    // ****************************************
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int t = 0; t < 4; t++) begin
            for (int p = 0; p < 16; p++) begin
                load(2'(t), 4'(p), 32'h8000 + ($random(seed) & 32'hffff));
            end
        end
        $display("test load done");
        for (int i = 0; i < 120; i++) begin
            r.valid = 1'b1;
            r.task_id = 2'($random(seed));
            r.ptr_sel = 4'($random(seed));
            r.mode = irag_pkg::irag_mode_t'(3'(i % 5));
            r.step_two = 1'($random(seed));
            r.is_bit = 1'($random(seed));
            r.const_ofs = (i < 5) ? 12'h800 : (i < 10) ? 12'h7ff : 12'($random(seed));
            r.reg_ofs = (i < 5) ? 16'h8000 : 16'($random(seed));
            ind(r);
        end
        load(2'h0, 4'h1, irag_pkg::MEM_LIMIT_DEF - 32'h1);
        ind('{1'b1, 2'h0, 4'h1, irag_pkg::IRAG_AM_POSTINC, 1'b0, 1'b0, 12'h0, 16'h0});
        plain(2'h0, 4'h1);
        $display("test modes done");
        op = op.first();
        repeat (op.num()) begin
            w = $random(seed);
            eng.dir('{1'b1, 2'h0, 4'hf, op, w});
            @(negedge ref_clk_i);
            cmp(dres_o.refused, op == irag_pkg::IRAG_OP_OTHER, "refused");
            cmp(dres_o.rdata, m[0][15], "dold");
            m[0][15] = dop(op, m[0][15], w);
            op = op.next();
        end
        load(2'h0, 4'hf, 32'h9000);
        @(posedge ref_clk_i);
        found_valid_i <= 1'b1;
        found_task_i <= 2'h2;
        found_addr_i <= 32'h0001_2340;
        @(posedge ref_clk_i);
        found_valid_i <= 1'b0;
        m[2][0] = 32'h0001_2340;
        plain(2'h2, 4'h0);
        @(posedge ref_clk_i);
        tool_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        tool_rd_i <= 1'b0;
        tool_wr_i <= 1'b1;
        @(negedge ref_clk_i);
        cmp(tool_rdata_o, m[2][0], "tool");
        @(posedge ref_clk_i);
        tool_wr_i <= 1'b0;
        host_req_i <= 1'b1;
        @(negedge ref_clk_i);
        cmp(tool_err_o, 1'b1, "twr");
        @(posedge ref_clk_i);
        host_req_i <= 1'b0;
        @(negedge ref_clk_i);
        cmp(host_err_o, 1'b1, "host");
        plain(2'h2, 4'h0);
        $display("test ops done");
        ctl(5'b10010);
        ctl(5'b00110);
        ctl(5'b01011);
        ctl(5'b01010);
        load(2'h1, 4'h3, 32'h8888);
        ctl(5'b10000);
        $display("test retain done");
        @(posedge ref_clk_i);
        share_banks_i <= 1'b1;
        load(2'h1, 4'h5, 32'h7777);
        plain(2'h3, 4'h5);
        $display("test share done");
        end_sim;
    end
    // Cuts a hang short well beyond the expected run of about 45 microseconds.
    initial begin
        #1000000;
        mismatches++;
        end_sim;
    end
endmodule
